// file: design/flash_pkg.sv
package flash_pkg;

    // ----------------------------------------------------------------
    // register byte offsets on the control bus
    // ----------------------------------------------------------------
    localparam logic [7:0] CTRL_OFF = 8'h00;
    localparam logic [7:0] CFG_OFF  = 8'h04;
    localparam logic [7:0] STAT_OFF = 8'h08;
    localparam logic [7:0] ADDR_OFF = 8'h0c;
    localparam logic [7:0] DATA_OFF = 8'h10;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int CTRL_HV      = 0;
    localparam int CTRL_LAT     = 1;
    localparam int CTRL_ERS     = 2;
    localparam int CTRL_LATCHED = 3;
    localparam int CFG_GUARD    = 0;
    localparam int CFG_DLY      = 1;
    localparam int ADDR_SIZE    = 16;

    // ----------------------------------------------------------------
    // array geometry, reset values and timing
    // ----------------------------------------------------------------
    localparam int         ARRAY_BYTES = 32768;
    localparam logic [1:0] BOOT_SEL    = 2'b11;   // top 8 KB of the array
    localparam logic       GUARD_RST   = 1'b1;
    localparam logic       DLY_RST     = 1'b0;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam int         WAKE_NS     = 250;
    localparam int         CLK_MHZ     = 50;
    localparam int         WAKE_CYC    = (WAKE_NS * CLK_MHZ + 999) / 1000;

    typedef enum logic [1:0] {
        RD_IDLE = 2'b00,
        RD_WAIT = 2'b01,
        RD_RESP = 2'b10
    } rd_phase_t;

    typedef struct packed {
        logic hv;
        logic lat;
        logic ers;
        logic latched;
    } ctrl_t;

    typedef struct packed {
        logic        aw_full;
        logic [7:0]  aw_addr;
        logic        w_full;
        logic [31:0] wdata;
        logic        b_valid;
        logic [1:0]  bresp;
        rd_phase_t   rd_phase;
        logic [7:0]  rd_addr;
        logic        rd_extra;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        ctrl_t       ctl;
        logic        guard;
        logic        dly;
        logic [14:0] lat_addr;
        logic [15:0] lat_data;
        logic        lat_word;
        logic [14:0] acc_addr;
        logic        acc_byte;
        logic [3:0]  wake;
        logic        stop_q;
    } state_t;

endpackage : flash_pkg

// file: design/flash_program_erase_interlock.sv
// The AXI4-Lite register port and the address map are this design's own decisions.
`timescale 1ns/10ps
// Notes on behaviour
// - byte/aligned read one cycle, misaligned adds one
// - normal array writes are discarded
// - erased reads one, program only clears bits
// - program width from size bit and addr0
// - first array write after latch enable captures
// - later array writes ignored, control writes proceed
// - hv apply needs latch enable and capture
// - latch enable cannot clear while hv applied
// - erase select frozen while hv applied
// - latch, capture, hv on separate writes
// - erase any address; boot only unguarded
// - guarded boot block program capture ignored
// - reprogramming without erase only clears bits
// - stop or wait halts programming at once
// - stop exit wake delay before array data reads, not before programming
// - array reads depend on control bits
// - erase acts on all unguarded locations together
// - hv set with latch clear does nothing
// - boot guard blocks program capture and erase
module flash_program_erase_interlock (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    input  wire logic [7:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    input  wire logic        stop_mode,
    input  wire logic        wait_mode,
    input  wire logic        program_voltage_pin,
    output logic             hv_enable
);

    flash_pkg::state_t s;
    flash_pkg::state_t next_s;

    // nonvolatile cells, big-endian pairs: even byte is the high half
    logic [7:0] cells [0:flash_pkg::ARRAY_BYTES-1];

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic in_boot(input logic [14:0] a);
        return a[14:13] == flash_pkg::BOOT_SEL;
    endfunction : in_boot

    function automatic logic [7:0] word_off(input logic [7:0] a);
        return {a[7:2], 2'b00};
    endfunction : word_off

    function automatic logic mapped(input logic [7:0] a);
        logic [7:0] w;
        w = word_off(a);
        return w == flash_pkg::CTRL_OFF || w == flash_pkg::CFG_OFF || w == flash_pkg::STAT_OFF
            || w == flash_pkg::ADDR_OFF || w == flash_pkg::DATA_OFF;
    endfunction : mapped

    // ----------------------------------------------------------------
    // high voltage gate and bus handshakes
    // ----------------------------------------------------------------
    // halting is combinational so no cycle of stress slips past a stop
    assign hv_enable = s.ctl.hv && !stop_mode && !wait_mode;
    assign awready   = !s.aw_full && !s.b_valid;
    assign wready    = !s.w_full && !s.b_valid;
    assign arready   = s.rd_phase == flash_pkg::RD_IDLE;
    assign bvalid    = s.b_valid;
    assign bresp     = s.bresp;
    assign rvalid    = s.rd_phase == flash_pkg::RD_RESP;
    assign rdata     = s.rdata;
    assign rresp     = s.rresp;

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        logic [14:0] ra;
        logic [15:0] rd_word;
        logic        want_hv;
        logic        new_lat;
        logic        cap_word;
        next_s   = s;
        ra       = 15'h0000;
        rd_word  = 16'h0000;
        want_hv  = 1'b0;
        new_lat  = 1'b0;
        cap_word = 1'b0;

        // wake timer restarts on every stop exit
        next_s.stop_q = stop_mode;
        if (s.stop_q && !stop_mode) begin
            next_s.wake = 4'(flash_pkg::WAKE_CYC);
        end else if (s.wake != 4'h0) begin
            next_s.wake = s.wake - 4'h1;
        end

        // collect address and data in either order
        if (awvalid && awready) begin
            next_s.aw_full = 1'b1;
            next_s.aw_addr = awaddr;
        end
        if (wvalid && wready) begin
            next_s.w_full = 1'b1;
            next_s.wdata  = wdata;
        end

        // perform a write once both halves are held
        if (s.aw_full && s.w_full) begin
            next_s.aw_full = 1'b0;
            next_s.w_full  = 1'b0;
            next_s.b_valid = 1'b1;
            next_s.bresp   = mapped(s.aw_addr) ? flash_pkg::RESP_OKAY : flash_pkg::RESP_SLVERR;
            unique case (word_off(s.aw_addr))
                flash_pkg::CTRL_OFF: begin
                    want_hv = s.wdata[flash_pkg::CTRL_HV];
                    if (s.ctl.hv) begin
                        next_s.ctl.hv = want_hv;
                    end else begin
                        // latch enable refuses to rise without programming voltage
                        new_lat = s.wdata[flash_pkg::CTRL_LAT] && (s.ctl.lat || program_voltage_pin);
                        next_s.ctl.lat = new_lat;
                        next_s.ctl.ers = s.wdata[flash_pkg::CTRL_ERS];
                        if (!new_lat || !s.ctl.lat) begin
                            next_s.ctl.latched = 1'b0;
                        end
                        next_s.ctl.hv = want_hv && s.ctl.lat && s.ctl.latched && new_lat;
                    end
                end
                flash_pkg::CFG_OFF: begin
                    if (!s.ctl.hv) begin
                        next_s.guard = s.wdata[flash_pkg::CFG_GUARD];
                    end
                    next_s.dly = s.wdata[flash_pkg::CFG_DLY];
                end
                flash_pkg::ADDR_OFF: begin
                    next_s.acc_addr = s.wdata[14:0];
                    next_s.acc_byte = s.wdata[flash_pkg::ADDR_SIZE];
                end
                flash_pkg::DATA_OFF: begin
                    // word only when size says word and address is even
                    cap_word = !s.acc_byte && !s.acc_addr[0];
                    if (s.ctl.lat && !s.ctl.latched && !s.ctl.hv
                        && !(!s.ctl.ers && s.guard && in_boot(s.acc_addr))) begin
                        next_s.ctl.latched = 1'b1;
                        next_s.lat_addr    = s.acc_addr;
                        next_s.lat_word    = cap_word;
                        next_s.lat_data    = cap_word ? s.wdata[15:0] : {8'h00, s.wdata[7:0]};
                    end
                    // any other array write leaves the cells alone
                end
                default: begin
                end
            endcase
        end
        if (s.b_valid && bready) begin
            next_s.b_valid = 1'b0;
        end

        // read path: misaligned words and the wake hold add cycles
        unique case (s.rd_phase)
            flash_pkg::RD_IDLE: begin
                if (arvalid) begin
                    next_s.rd_addr  = araddr;
                    next_s.rd_extra = word_off(araddr) == flash_pkg::DATA_OFF
                                      && !s.acc_byte && s.acc_addr[0];
                    next_s.rd_phase = flash_pkg::RD_WAIT;
                end
            end
            flash_pkg::RD_WAIT: begin
                if (s.rd_extra) begin
                    next_s.rd_extra = 1'b0;
                end else if (!(s.dly && s.wake != 4'h0 && word_off(s.rd_addr) == flash_pkg::DATA_OFF)) begin
                    next_s.rd_phase = flash_pkg::RD_RESP;
                    next_s.rresp    = mapped(s.rd_addr) ? flash_pkg::RESP_OKAY : flash_pkg::RESP_SLVERR;
                    next_s.rdata    = 32'h0000_0000;
                    unique case (word_off(s.rd_addr))
                        flash_pkg::CTRL_OFF: begin
                            next_s.rdata[3:0] = {s.ctl.latched, s.ctl.ers, s.ctl.lat, s.ctl.hv};
                        end
                        flash_pkg::CFG_OFF: begin
                            next_s.rdata[1:0] = {s.dly, s.guard};
                        end
                        flash_pkg::STAT_OFF: begin
                            next_s.rdata[4:0] = {program_voltage_pin, wait_mode, stop_mode,
                                                 s.wake == 4'h0, hv_enable};
                        end
                        flash_pkg::ADDR_OFF: begin
                            next_s.rdata[16:0] = {s.acc_byte, 1'b0, s.acc_addr};
                        end
                        flash_pkg::DATA_OFF: begin
                            // program mode with latches open shows the target cell
                            ra = (s.ctl.lat && !s.ctl.ers) ? s.lat_addr : s.acc_addr;
                            rd_word = {cells[ra], cells[15'(ra + 15'h0001)]};
                            if (s.ctl.hv) begin
                                next_s.rdata = 32'h0000_0000;
                            end else if (s.acc_byte) begin
                                next_s.rdata[7:0] = rd_word[15:8];
                            end else begin
                                next_s.rdata[15:0] = rd_word;
                            end
                        end
                        default: begin
                        end
                    endcase
                end
            end
            flash_pkg::RD_RESP: begin
                if (rready) begin
                    next_s.rd_phase = flash_pkg::RD_IDLE;
                end
            end
            default: begin
                next_s.rd_phase = flash_pkg::RD_IDLE;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s          <= '0;
            s.rd_phase <= flash_pkg::RD_IDLE;
            s.guard    <= flash_pkg::GUARD_RST;
            s.dly      <= flash_pkg::DLY_RST;
        end else begin
            s <= next_s;
        end
    end

    // ----------------------------------------------------------------
    // cell array: erase and program while voltage is applied
    // ----------------------------------------------------------------
    // contents survive reset, so the array has no reset branch
    always_ff @(posedge aclk) begin
        if (hv_enable && s.ctl.lat && s.ctl.ers) begin
            for (int i = 0; i < flash_pkg::ARRAY_BYTES; i++) begin
                if (!(s.guard && in_boot(15'(i)))) begin
                    cells[i] <= 8'hff;
                end
            end
        end else if (hv_enable && s.ctl.lat) begin
            // and-ing can only pull ones to zero
            if (s.lat_word) begin
                cells[s.lat_addr] <= cells[s.lat_addr] & s.lat_data[15:8];
                cells[{s.lat_addr[14:1], 1'b1}] <= cells[{s.lat_addr[14:1], 1'b1}] & s.lat_data[7:0];
            end else begin
                cells[s.lat_addr] <= cells[s.lat_addr] & s.lat_data[7:0];
            end
        end
    end

endmodule : flash_program_erase_interlock

// file: tb/flash_program_erase_interlock_sva.sv
`timescale 1ns/10ps
module flash_program_erase_interlock_sva (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic awvalid,
    input wire logic awready,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic bvalid,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic rvalid,
    input wire logic stop_mode,
    input wire logic wait_mode,
    input wire logic hv_enable
);
    // one clock domain, so reset masks every check from one place
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    property p_hv_gate; (stop_mode || wait_mode) |-> !hv_enable; endproperty
    a_hv_gate: assert property (p_hv_gate) else $error("hv on in stop or wait");
    property p_hv_rise; $rose(hv_enable) && !$past(stop_mode) && !$past(wait_mode) |-> $rose(bvalid); endproperty
    a_hv_rise: assert property (p_hv_rise) else $error("hv rose without a write");
    property p_hv_fall; (hv_enable && !stop_mode && !wait_mode) ##1 (!hv_enable && !stop_mode && !wait_mode)
        |-> $rose(bvalid); endproperty
    a_hv_fall: assert property (p_hv_fall) else $error("hv fell without a write");
    property p_rd_early; arvalid && arready |=> !rvalid; endproperty
    a_rd_early: assert property (p_rd_early) else $error("read answered too soon");
    property p_rd_bound; arvalid && arready |-> ##[2:20] rvalid; endproperty
    a_rd_bound: assert property (p_rd_bound) else $error("read answer late");
    property p_ar_block; rvalid |-> !arready; endproperty
    a_ar_block: assert property (p_ar_block) else $error("second read taken");
    property p_b_block; bvalid |-> !awready && !wready; endproperty
    a_b_block: assert property (p_b_block) else $error("write taken during response");
    property p_wr_time; awvalid && awready && wvalid && wready |=> !bvalid ##1 bvalid; endproperty
    a_wr_time: assert property (p_wr_time) else $error("write response timing");
endmodule : flash_program_erase_interlock_sva

bind flash_program_erase_interlock flash_program_erase_interlock_sva u_sva (
    .aclk, .aresetn, .awvalid, .awready, .wvalid, .wready, .bvalid,
    .arvalid, .arready, .rvalid, .stop_mode, .wait_mode, .hv_enable
);

// file: tb/cpu_model.sv
`timescale 1ns/10ps
module cpu_model (
    input  wire logic        aclk,
    output logic [7:0]       awaddr,
    output logic             awvalid,
    input  wire logic        awready,
    output logic [31:0]      wdata,
    output logic [3:0]       wstrb,
    output logic             wvalid,
    input  wire logic        wready,
    input  wire logic [1:0]  bresp,
    input  wire logic        bvalid,
    output logic             bready,
    output logic [7:0]       araddr,
    output logic             arvalid,
    input  wire logic        arready,
    input  wire logic [31:0] rdata,
    input  wire logic [1:0]  rresp,
    input  wire logic        rvalid,
    output logic             rready
);
    // answers are always accepted, so ready never has to toggle
    initial begin
        {awaddr, wdata, araddr, awvalid, wvalid, arvalid} = '0;
        {wstrb, bready, rready} = 6'h3f;
    end
    // both halves offered together; each dropped, payload inverted, at its own handshake
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aw_p, w_p, aw_h, w_h;
        {aw_p, w_p} = 2'h3;
        {awaddr, wdata, awvalid, wvalid} <= {a, d, 2'h3};
        while (aw_p || w_p) begin
            @(negedge aclk);
            {aw_h, w_h} = {aw_p && awready, w_p && wready};
            @(posedge aclk);
            if (aw_h) {awvalid, awaddr} <= {1'h0, ~a};
            if (w_h) {wvalid, wdata} <= {1'h0, ~d};
            {aw_p, w_p} = {aw_p && !aw_h, w_p && !w_h};
        end
        do begin
            @(negedge aclk);
            {aw_h, r} = {bvalid, bresp};
            @(posedge aclk);
        end while (!aw_h);
    endtask : wr
    // the program and erase procedures are sequenced by the caller, one bus cycle at a time
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic h;
        {araddr, arvalid} <= {a, 1'h1};
        do begin
            @(negedge aclk);
            h = arready;
            @(posedge aclk);
        end while (!h);
        {arvalid, araddr} <= {1'h0, ~a};
        do begin
            @(negedge aclk);
            {h, d, r} = {rvalid, rdata, rresp};
            @(posedge aclk);
        end while (!h);
    endtask : rd
endmodule : cpu_model

// file: tb/flash_program_erase_interlock_tb.sv
`timescale 1ns/10ps
module flash_program_erase_interlock_tb;
    // ----------------------------------------------------------------
    // stimulus table: flags {pin, stop, wait, write}, write, read, expectations
    // ----------------------------------------------------------------
    localparam logic [7:0] CTL = flash_pkg::CTRL_OFF, CFG = flash_pkg::CFG_OFF;
    localparam logic [7:0] ADR = flash_pkg::ADDR_OFF, DAT = flash_pkg::DATA_OFF;
    localparam logic [1:0] OK = flash_pkg::RESP_OKAY, ER = flash_pkg::RESP_SLVERR;
    typedef struct packed {
        logic [3:0] f; logic [7:0] wa; logic [31:0] wd; logic [7:0] ra; logic [31:0] re; logic [1:0] rs; logic hv;
    } row_t;
    row_t rows [29] = '{
        '{4'h0, 8'h00, 32'h0, CTL, 32'h0, OK, 1'h0},
        '{4'h0, 8'h00, 32'h0, CFG, 32'h1, OK, 1'h0},
        '{4'h1, 8'h14, 32'h1, 8'h14, 32'h0, ER, 1'h0},         // unmapped place
        '{4'h1, CTL, 32'h6, CTL, 32'h4, OK, 1'h0},
        '{4'h9, CTL, 32'h7, CTL, 32'h6, OK, 1'h0},
        '{4'h9, DAT, 32'h5a, CTL, 32'he, OK, 1'h0},
        '{4'h9, CTL, 32'h7, CTL, 32'hf, OK, 1'h1},
        '{4'h9, CTL, 32'h1, CTL, 32'hf, OK, 1'h1},
        '{4'hc, 8'h00, 32'h0, DAT, 32'h0, OK, 1'h0},
        '{4'ha, 8'h00, 32'h0, CTL, 32'hf, OK, 1'h0},
        '{4'h9, CTL, 32'h6, CTL, 32'he, OK, 1'h0},
        '{4'h9, CTL, 32'h0, CTL, 32'h0, OK, 1'h0},
        '{4'h9, ADR, 32'h10, DAT, 32'hffff, OK, 1'h0},
        '{4'h9, CTL, 32'h2, CTL, 32'h2, OK, 1'h0},
        '{4'h9, DAT, 32'h1234, CTL, 32'ha, OK, 1'h0},
        '{4'h9, DAT, 32'h0, DAT, 32'hffff, OK, 1'h0},
        '{4'h9, CTL, 32'h3, CTL, 32'hb, OK, 1'h1},
        '{4'h9, CTL, 32'h2, DAT, 32'h1234, OK, 1'h0},
        '{4'h9, CTL, 32'h1, CTL, 32'h0, OK, 1'h0},
        '{4'h9, ADR, 32'h1_0011, DAT, 32'h34, OK, 1'h0},
        '{4'h9, CTL, 32'h2, CTL, 32'h2, OK, 1'h0},
        '{4'h9, DAT, 32'h30, CTL, 32'ha, OK, 1'h0},
        '{4'h9, CTL, 32'h3, CTL, 32'hb, OK, 1'h1},
        '{4'h9, CTL, 32'h2, CTL, 32'ha, OK, 1'h0},
        '{4'h9, CTL, 32'h0, DAT, 32'h30, OK, 1'h0},
        '{4'h9, DAT, 32'hff, DAT, 32'h30, OK, 1'h0},
        '{4'h9, ADR, 32'h6000, ADR, 32'h6000, OK, 1'h0},
        '{4'h9, CTL, 32'h2, CTL, 32'h2, OK, 1'h0},
        '{4'h9, DAT, 32'h0, CTL, 32'h2, OK, 1'h0}
    };
    logic        aclk = 1'h0;
    logic        aresetn = 1'h0;
    logic        stop_mode = 1'h0;
    logic        wait_mode = 1'h0;
    logic        program_voltage_pin = 1'h0;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, got;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, resp;
    logic        awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready, hv_enable;
    int          n_errors = 0;
    int          check_count = 0;
    int          cyc = 0;
    flash_program_erase_interlock u_flash_program_erase_interlock (
        .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid,
        .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .stop_mode, .wait_mode,
        .program_voltage_pin, .hv_enable
    );
    cpu_model u_cpu_model (
        .aclk, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready,
        .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready
    );
    always #10 aclk = ~aclk;
    // a hang anywhere in the handshakes ends up here instead of running forever
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_errors++;
            close_out();
        end
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e) begin
            n_errors++;
            $display("BAD %0t got %h want %h", $time, g, e);
        end
    endtask : chk
    task automatic close_out();
        if (n_errors == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : close_out
    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);
        foreach (rows[i]) begin
            {program_voltage_pin, stop_mode, wait_mode} <= rows[i].f[3:1];
            if (rows[i].f[0]) begin
                u_cpu_model.wr(rows[i].wa, rows[i].wd, resp);
                chk({30'h0, resp}, {30'h0, rows[i].rs});
            end
            u_cpu_model.rd(rows[i].ra, got, resp);
            chk(got, rows[i].re);
            chk({30'h0, resp}, {30'h0, rows[i].rs});
            chk({31'h0, hv_enable}, {31'h0, rows[i].hv});
        end
        // misaligned word read takes the extra cycle but still answers cleanly
        u_cpu_model.wr(ADR, 32'h11, resp);
        u_cpu_model.rd(DAT, got, resp);
        chk({30'h0, resp}, {30'h0, OK});
        close_out();
    end
endmodule : flash_program_erase_interlock_tb
